// *** hdl/csr_pkg.sv ***
// Package: constants and carrier types for the CPU state block
// Summary of operation
// - Flag bit 7 gates every interrupt
// - Interrupt entry clears it, irq return sets
// - Dedicated set and clear ops for it
// - Bit 6 is bit copy flag
// - Bit 5 holds low nibble carry
// - Bit 4 always equals negative xor overflow
// - Bit 3 holds signed overflow
// - Bit 2 set on negative result
// - Bit 1 set on zero result
// - Bit 0 holds result carry
// - Each ALU operation updates the flags its mask selects
// - Flags not saved or restored on interrupts
// - Four register file port schemes supported
// - Registers at data addresses 0x00 to 0x1F
// - Top six registers form three pointers
// - Pointer displacement, post-increment, pre-decrement
// - Byte push decrements, pop increments by one
// - Call or irq minus two, returns plus two
// - Stack pointer two bytes, reset to zero
// - Core runs on undivided clock
// - Read, operate, write back in one cycle
`default_nettype none
package csr_pkg;
  localparam int unsigned FLG_IE    = 7;
  localparam int unsigned FLG_T     = 6;
  localparam int unsigned FLG_H     = 5;
  localparam int unsigned FLG_S     = 4;
  localparam int unsigned FLG_V     = 3;
  localparam int unsigned FLG_N     = 2;
  localparam int unsigned FLG_Z     = 1;
  localparam int unsigned FLG_C     = 0;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST    = 16'h0000;
  localparam int unsigned NREG      = 32;
  localparam logic [4:0]  PTR_BASE  = 5'h1a;  // Low byte of the first pointer pair
  localparam logic [15:0] DATA_TOP  = 16'h001f;

  // Stack operation codes
  typedef enum logic [2:0] {
    CSR_SP_NONE = 3'h0,
    CSR_SP_PUSH = 3'h1,
    CSR_SP_POP  = 3'h2,
    CSR_SP_CALL = 3'h3,
    CSR_SP_RET  = 3'h4
  } csr_sp_op_t;

  // Pointer addressing variants
  typedef enum logic [1:0] {
    CSR_PM_DISP = 2'h0,
    CSR_PM_POST = 2'h1,
    CSR_PM_PRE  = 2'h2
  } csr_ptr_mode_t;

  // ALU flag result with per-flag update mask
  typedef struct packed {
    logic       upd_h;
    logic       upd_v;
    logic       upd_n;
    logic       upd_z;
    logic       upd_c;
    logic       h;
    logic       v;
    logic       n;
    logic       z;
    logic       c;
  } csr_alu_flags_t;

  // Register file write port
  typedef struct packed {
    logic        we8;
    logic        we16;
    logic [4:0]  addr;
    logic [15:0] data;
  } csr_rf_wr_t;
endpackage
`default_nettype wire

// *** hdl/csr_core_state.sv ***
// Module: status flags, 32x8 register file and stack pointer
`default_nettype none
module csr_core_state (
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  // ALU result flags
  input  wire logic                    ALU_VALID,
  input  wire csr_pkg::csr_alu_flags_t ALU_FLAGS,
  // Interrupt and flag control
  input  wire logic                    IRQ_TAKE,
  input  wire logic                    IRQ_RETURN,
  input  wire logic                    IE_SET,
  input  wire logic                    IE_CLR,
  input  wire logic                    FLAGS_WE,
  input  wire logic [7:0]              FLAGS_WDATA,
  output logic [7:0]                   FLAGS_RDATA,
  output logic                         IRQ_ALLOWED,
  input  wire logic                    ANY_IRQ_PENDING,
  // Bit copy
  input  wire logic                    BIT_STORE,
  input  wire logic                    BIT_LOAD,
  input  wire logic [2:0]              BIT_SEL,
  input  wire logic [4:0]              BIT_REG,
  // Register file read ports and write port
  input  wire logic [4:0]              RD_A_ADDR,
  input  wire logic [4:0]              RD_B_ADDR,
  output logic [7:0]                   RD_A_DATA,
  output logic [7:0]                   RD_B_DATA,
  output logic [15:0]                  RD_W_DATA,
  input  wire csr_pkg::csr_rf_wr_t     RF_WR,
  // Data space access to the register file
  input  wire logic [15:0]             DS_ADDR,
  input  wire logic                    DS_WE,
  input  wire logic [7:0]              DS_WDATA,
  output logic                         DS_HIT,
  output logic [7:0]                   DS_RDATA,
  // Indirect pointers
  input  wire logic                    PTR_EN,
  input  wire logic [1:0]              PTR_SEL,
  input  wire csr_pkg::csr_ptr_mode_t  PTR_MODE,
  input  wire logic [5:0]              PTR_DISP,
  output logic [15:0]                  PTR_ADDR,
  // Stack pointer
  input  wire csr_pkg::csr_sp_op_t     SP_OP,
  input  wire logic                    SPH_WE,
  input  wire logic                    SPL_WE,
  input  wire logic [7:0]              SP_WDATA,
  output logic [7:0]                   SPH_RDATA,
  output logic [7:0]                   SPL_RDATA
);

  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  rf_q [csr_pkg::NREG];
  logic [15:0] sp_q;
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ptr_upd;
  logic        ptr_we;

  // Pointer pair selection; low byte in the lower register
  assign ptr_lo  = 5'(csr_pkg::PTR_BASE + {2'(PTR_SEL), 1'b0});
  assign ptr_val = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
  assign ptr_we  = PTR_EN && PTR_SEL != 2'h3 && PTR_MODE != csr_pkg::CSR_PM_DISP;
  assign ptr_upd = (PTR_MODE == csr_pkg::CSR_PM_POST) ? ptr_val + 16'h0001
                                                     : ptr_val - 16'h0001;

  // Effective address per variant
  always_comb begin
    unique case (PTR_MODE)
      csr_pkg::CSR_PM_DISP: PTR_ADDR = ptr_val + {10'h000, PTR_DISP};
      csr_pkg::CSR_PM_PRE:  PTR_ADDR = ptr_upd;
      default:              PTR_ADDR = ptr_val;
    endcase
  end

  // Next flag byte; hardware updates override in listed priority, so a
  // clear of the interrupt enable always beats a set in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (FLAGS_WE) begin
      flags_d = FLAGS_WDATA;
    end
    if (ALU_VALID) begin
      if (ALU_FLAGS.upd_h) flags_d[csr_pkg::FLG_H] = ALU_FLAGS.h;
      if (ALU_FLAGS.upd_v) flags_d[csr_pkg::FLG_V] = ALU_FLAGS.v;
      if (ALU_FLAGS.upd_n) flags_d[csr_pkg::FLG_N] = ALU_FLAGS.n;
      if (ALU_FLAGS.upd_z) flags_d[csr_pkg::FLG_Z] = ALU_FLAGS.z;
      if (ALU_FLAGS.upd_c) flags_d[csr_pkg::FLG_C] = ALU_FLAGS.c;
    end
    if (BIT_STORE) begin
      flags_d[csr_pkg::FLG_T] = rf_q[BIT_REG][BIT_SEL];
    end
    if (IE_SET || IRQ_RETURN) flags_d[csr_pkg::FLG_IE] = 1'b1;
    if (IE_CLR || IRQ_TAKE)   flags_d[csr_pkg::FLG_IE] = 1'b0;
    // Sign is derived, never stored independently
    flags_d[csr_pkg::FLG_S] = flags_d[csr_pkg::FLG_N] ^ flags_d[csr_pkg::FLG_V];
  end

  // Flag register on the undivided core clock, like every register here
  // Nothing pushes or pops the flags on interrupts; software must save them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= csr_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign FLAGS_RDATA = flags_q;
  // Clear takes effect at once, so no interrupt slips past it
  assign IRQ_ALLOWED = flags_q[csr_pkg::FLG_IE] && !IE_CLR && ANY_IRQ_PENDING;

  // Register file writes; pointer update last since it wins the same entry
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < csr_pkg::NREG; i++) rf_q[i] <= 8'h00;
    end else begin
      if (RF_WR.we8) rf_q[RF_WR.addr] <= RF_WR.data[7:0];
      if (RF_WR.we16) begin
        rf_q[{RF_WR.addr[4:1], 1'b0}] <= RF_WR.data[7:0];
        rf_q[{RF_WR.addr[4:1], 1'b1}] <= RF_WR.data[15:8];
      end
      if (DS_WE && DS_HIT) rf_q[DS_ADDR[4:0]] <= DS_WDATA;
      if (BIT_LOAD) rf_q[BIT_REG][BIT_SEL] <= flags_q[csr_pkg::FLG_T];
      if (ptr_we) begin
        rf_q[ptr_lo]         <= ptr_upd[7:0];
        rf_q[ptr_lo + 5'h01] <= ptr_upd[15:8];
      end
    end
  end

  // Combinational reads give same-cycle operands to the ALU
  assign RD_A_DATA = rf_q[RD_A_ADDR];
  assign RD_B_DATA = rf_q[RD_B_ADDR];
  assign RD_W_DATA = {rf_q[{RD_A_ADDR[4:1], 1'b1}], rf_q[{RD_A_ADDR[4:1], 1'b0}]};
  assign DS_HIT    = DS_ADDR <= csr_pkg::DATA_TOP;
  assign DS_RDATA  = DS_HIT ? rf_q[DS_ADDR[4:0]] : 8'h00;

  // Stack pointer; program must load it above 0x60 before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sp_q <= csr_pkg::SP_RST;
    end else begin
      unique case (SP_OP)
        csr_pkg::CSR_SP_PUSH: sp_q <= sp_q - 16'h0001;
        csr_pkg::CSR_SP_POP:  sp_q <= sp_q + 16'h0001;
        csr_pkg::CSR_SP_CALL: sp_q <= sp_q - 16'h0002;
        csr_pkg::CSR_SP_RET:  sp_q <= sp_q + 16'h0002;
        default: begin
          if (SPH_WE) sp_q[15:8] <= SP_WDATA;
          if (SPL_WE) sp_q[7:0]  <= SP_WDATA;
        end
      endcase
    end
  end

  assign SPH_RDATA = sp_q[15:8];
  assign SPL_RDATA = sp_q[7:0];

  // Checks
  a_sign_xor: assert property (@(posedge CLK) disable iff (!RST_N)
    flags_q[csr_pkg::FLG_S] == (flags_q[csr_pkg::FLG_N] ^ flags_q[csr_pkg::FLG_V]))
    else $error("sign flag not n xor v");
  a_ie_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    !flags_q[csr_pkg::FLG_IE] |-> !IRQ_ALLOWED) else $error("irq allowed with ie low");
  a_irq_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ_TAKE |=> !flags_q[csr_pkg::FLG_IE]) else $error("ie not cleared on entry");
  a_ret_set: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ_RETURN && !IE_CLR && !IRQ_TAKE |=> flags_q[csr_pkg::FLG_IE])
    else $error("ie not set on return");
  a_sp_push: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_PUSH |=> sp_q == $past(sp_q) - 16'h0001)
    else $error("push did not decrement by one");
  a_sp_call: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_CALL |=> sp_q == $past(sp_q) - 16'h0002)
    else $error("call did not decrement by two");
  a_sp_ret: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_RET |=> sp_q == $past(sp_q) + 16'h0002)
    else $error("return did not increment by two");
  a_zero_upd: assert property (@(posedge CLK) disable iff (!RST_N)
    ALU_VALID && ALU_FLAGS.upd_z |=> flags_q[csr_pkg::FLG_Z] == $past(ALU_FLAGS.z))
    else $error("zero flag not updated");
  a_carry_upd: assert property (@(posedge CLK) disable iff (!RST_N)
    ALU_VALID && ALU_FLAGS.upd_c |=> flags_q[csr_pkg::FLG_C] == $past(ALU_FLAGS.c))
    else $error("carry flag not updated");
  a_flag_write: assert property (@(posedge CLK) disable iff (!RST_N)
    FLAGS_WE && !ALU_VALID && !BIT_STORE && !IE_SET && !IE_CLR && !IRQ_TAKE
      && !IRQ_RETURN |=> flags_q[6:5] == $past(FLAGS_WDATA[6:5]))
    else $error("flag byte write not stored");

  // Named steps shared by the checks below
  // No source of a flag change is active in this cycle
  sequence s_flags_quiet;
    !FLAGS_WE && !ALU_VALID && !BIT_STORE && !IE_SET && !IE_CLR && !IRQ_TAKE && !IRQ_RETURN;
  endsequence
  // A pointer update request that the block honours
  sequence s_ptr_step;
    PTR_EN && PTR_SEL != 2'h3 && PTR_MODE != csr_pkg::CSR_PM_DISP;
  endsequence
  // No other register file writer competes in this cycle
  sequence s_rf_quiet;
    !RF_WR.we8 && !RF_WR.we16 && !DS_WE && !BIT_LOAD;
  endsequence

  // Half carry follows the ALU when requested
  a_half_upd: assert property (@(posedge CLK) disable iff (!RST_N)
    ALU_VALID && ALU_FLAGS.upd_h |=> flags_q[csr_pkg::FLG_H] == $past(ALU_FLAGS.h))
    else $error("half carry flag not updated");
  // Overflow follows the ALU when requested
  a_ovf_upd: assert property (@(posedge CLK) disable iff (!RST_N)
    ALU_VALID && ALU_FLAGS.upd_v |=> flags_q[csr_pkg::FLG_V] == $past(ALU_FLAGS.v))
    else $error("overflow flag not updated");
  // Negative follows the ALU when requested
  a_neg_upd: assert property (@(posedge CLK) disable iff (!RST_N)
    ALU_VALID && ALU_FLAGS.upd_n |=> flags_q[csr_pkg::FLG_N] == $past(ALU_FLAGS.n))
    else $error("negative flag not updated");
  // Set instruction raises the enable unless a clear competes
  a_ie_set: assert property (@(posedge CLK) disable iff (!RST_N)
    IE_SET && !IE_CLR && !IRQ_TAKE |=> flags_q[csr_pkg::FLG_IE])
    else $error("ie not set by set op");
  // Clear instruction always wins
  a_ie_clr: assert property (@(posedge CLK) disable iff (!RST_N)
    IE_CLR |=> !flags_q[csr_pkg::FLG_IE])
    else $error("ie not cleared by clear op");
  // A granted interrupt needs the enable, a pending source and no clear
  a_ie_allow: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ_ALLOWED |-> flags_q[csr_pkg::FLG_IE] && ANY_IRQ_PENDING && !IE_CLR)
    else $error("irq allowed without its conditions");
  // Bit store copies the chosen register bit into the copy flag
  a_bit_store: assert property (@(posedge CLK) disable iff (!RST_N)
    BIT_STORE |=> flags_q[csr_pkg::FLG_T] == $past(rf_q[BIT_REG][BIT_SEL]))
    else $error("bit store did not copy");
  // Bit load copies the flag into the chosen register bit
  a_bit_load: assert property (@(posedge CLK) disable iff (!RST_N)
    BIT_LOAD && !ptr_we |=>
      rf_q[$past(BIT_REG)][$past(BIT_SEL)] == $past(flags_q[csr_pkg::FLG_T]))
    else $error("bit load did not copy");
  // With no flag source active the byte holds
  a_flags_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    s_flags_quiet |=> $stable(flags_q))
    else $error("flags changed with no update");

  // Byte write lands when nothing of higher priority competes
  a_rf_byte: assert property (@(posedge CLK) disable iff (!RST_N)
    RF_WR.we8 && !RF_WR.we16 && !DS_WE && !BIT_LOAD && !ptr_we |=>
      rf_q[$past(RF_WR.addr)] == $past(RF_WR.data[7:0]))
    else $error("byte write not stored");
  // Pair write puts the low byte in the even register
  a_rf_pair: assert property (@(posedge CLK) disable iff (!RST_N)
    RF_WR.we16 && !DS_WE && !BIT_LOAD && !ptr_we |=>
      {rf_q[{$past(RF_WR.addr[4:1]), 1'b1}], rf_q[{$past(RF_WR.addr[4:1]), 1'b0}]}
        == $past(RF_WR.data))
    else $error("pair write not stored");
  // Wide read returns the even register of the pair in its low byte
  a_rd_pair: assert property (@(posedge CLK) disable iff (!RST_N)
    RD_W_DATA[7:0] == rf_q[{RD_A_ADDR[4:1], 1'b0}])
    else $error("wide read low byte wrong");
  // Data space write reaches the register file
  a_ds_write: assert property (@(posedge CLK) disable iff (!RST_N)
    DS_WE && DS_HIT && !BIT_LOAD && !ptr_we |=>
      rf_q[$past(DS_ADDR[4:0])] == $past(DS_WDATA))
    else $error("data space write not stored");
  // Addresses past the file read as zero
  a_ds_miss: assert property (@(posedge CLK) disable iff (!RST_N)
    DS_ADDR > csr_pkg::DATA_TOP |-> !DS_HIT && DS_RDATA == 8'h00)
    else $error("data space miss not empty");

  // Pointer update leaves the new value in its register pair
  a_ptr_update: assert property (@(posedge CLK) disable iff (!RST_N)
    s_ptr_step |=> {rf_q[$past(ptr_lo) + 5'h01], rf_q[$past(ptr_lo)]} == $past(ptr_upd))
    else $error("pointer not updated");
  // Post-increment addresses with the old pointer value
  a_ptr_post: assert property (@(posedge CLK) disable iff (!RST_N)
    PTR_MODE == csr_pkg::CSR_PM_POST |->
      PTR_ADDR == {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]})
    else $error("post-increment address wrong");
  // Pre-decrement addresses with the lowered value
  a_ptr_pre: assert property (@(posedge CLK) disable iff (!RST_N)
    PTR_MODE == csr_pkg::CSR_PM_PRE |->
      PTR_ADDR == {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]} - 16'h0001)
    else $error("pre-decrement address wrong");
  // An unused selector code leaves the top pair alone
  a_ptr_sel3: assert property (@(posedge CLK) disable iff (!RST_N)
    PTR_EN && PTR_SEL == 2'h3 ##0 s_rf_quiet |=> $stable({rf_q[5'h1f], rf_q[5'h1e]}))
    else $error("unused pointer selector wrote");

  // Pop raises the stack pointer by one
  a_sp_pop: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_POP |=> sp_q == $past(sp_q) + 16'h0001)
    else $error("pop did not increment by one");
  // High byte write when no stack operation competes
  a_sph_write: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_NONE && SPH_WE |=> sp_q[15:8] == $past(SP_WDATA))
    else $error("stack high byte write lost");
  // Low byte write when no stack operation competes
  a_spl_write: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_NONE && SPL_WE |=> sp_q[7:0] == $past(SP_WDATA))
    else $error("stack low byte write lost");
  // Idle stack pointer holds its value
  a_sp_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    SP_OP == csr_pkg::CSR_SP_NONE && !SPH_WE && !SPL_WE |=> $stable(sp_q))
    else $error("stack pointer moved while idle");
endmodule
`default_nettype wire

// *** verif/csr_alu_model.sv ***
// Partner model: adder standing in for the ALU that feeds the flag port
`default_nettype none
module csr_alu_model (
  input  wire logic [7:0]            a,
  input  wire logic [7:0]            b,
  output var  csr_pkg::csr_alu_flags_t flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sum;
  logic [4:0] lo;
  // Every add requests all five result flags, so none may go stale
  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    flags = {5'h1f, lo[4], (a[7] == b[7]) && (sum[7] != a[7]), sum[7],
             sum[7:0] == 8'h00, sum[8]};
  end
endmodule
`default_nettype wire

// *** verif/tb_cpu_status_regfile_stack.sv ***
// Testbench for the CPU state block: flags, register file, pointers, stack
`default_nettype none
module tb_cpu_status_regfile_stack;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        ALU_VALID, IRQ_TAKE, IRQ_RETURN, IE_SET, IE_CLR, FLAGS_WE, ANY_IRQ_PENDING;
  logic        BIT_STORE, BIT_LOAD, DS_WE, PTR_EN, SPH_WE, SPL_WE, IRQ_ALLOWED, DS_HIT;
  logic [1:0]  PTR_SEL;
  logic [2:0]  BIT_SEL;
  logic [4:0]  BIT_REG, RD_A_ADDR, RD_B_ADDR;
  logic [5:0]  PTR_DISP;
  logic [7:0]  FLAGS_WDATA, DS_WDATA, SP_WDATA, a_op, b_op, FLAGS_RDATA, RD_A_DATA;
  logic [7:0]  RD_B_DATA, DS_RDATA, SPH_RDATA, SPL_RDATA, e;
  logic [15:0] DS_ADDR, RD_W_DATA, PTR_ADDR;
  int          n_fail = 0;
  int          checks = 0;
  csr_pkg::csr_alu_flags_t ALU_FLAGS;
  csr_pkg::csr_rf_wr_t     RF_WR;
  csr_pkg::csr_ptr_mode_t  PTR_MODE;
  csr_pkg::csr_sp_op_t     SP_OP;
  // Rows: operand a, operand b, expected flag byte after the add
  logic [23:0] rows [4] = '{24'h080820, 24'h7f012c, 24'hff0123, 24'h80801b};
  csr_pkg::csr_sp_op_t sp_ops [4] = '{csr_pkg::CSR_SP_PUSH, csr_pkg::CSR_SP_POP,
                                      csr_pkg::CSR_SP_CALL, csr_pkg::CSR_SP_RET};
  logic [15:0] sp_exp [4] = '{16'h03ff, 16'h0400, 16'h03fe, 16'h0400};

  csr_alu_model alu (.a(a_op), .b(b_op), .flags(ALU_FLAGS));
  csr_core_state uut (.CLK, .RST_N, .ALU_VALID, .ALU_FLAGS, .IRQ_TAKE, .IRQ_RETURN, .IE_SET,
    .IE_CLR, .FLAGS_WE, .FLAGS_WDATA, .FLAGS_RDATA, .IRQ_ALLOWED, .ANY_IRQ_PENDING,
    .BIT_STORE, .BIT_LOAD, .BIT_SEL, .BIT_REG, .RD_A_ADDR, .RD_B_ADDR, .RD_A_DATA,
    .RD_B_DATA, .RD_W_DATA, .RF_WR, .DS_ADDR, .DS_WE, .DS_WDATA, .DS_HIT, .DS_RDATA,
    .PTR_EN, .PTR_SEL, .PTR_MODE, .PTR_DISP, .PTR_ADDR, .SP_OP, .SPH_WE, .SPL_WE,
    .SP_WDATA, .SPH_RDATA, .SPL_RDATA);

  // Free-running 100 MHz clock
  always #5 CLK = ~CLK;

  task automatic nx();
    @(negedge CLK);
  endtask
  // Drop every strobe; multi-bit selects keep their value
  task automatic clr();
    {ALU_VALID, IRQ_TAKE, IRQ_RETURN, IE_SET, IE_CLR, FLAGS_WE} = '0;
    {BIT_STORE, BIT_LOAD, DS_WE, PTR_EN, SPH_WE, SPL_WE} = '0;
    RF_WR = '0;
    SP_OP = csr_pkg::CSR_SP_NONE;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a microsecond
  initial begin
    #5000;
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clr();
    {ANY_IRQ_PENDING, FLAGS_WDATA, DS_WDATA, SP_WDATA, a_op, b_op, BIT_SEL} = '0;
    {BIT_REG, RD_A_ADDR, RD_B_ADDR, PTR_DISP, PTR_SEL, DS_ADDR} = '0;
    PTR_MODE = csr_pkg::CSR_PM_DISP;
    repeat (10) nx();
    RST_N = 1'b1;
    chk("flags", FLAGS_RDATA, 8'h00);
    chk("sp", {SPH_RDATA, SPL_RDATA}, 16'h0000);
    // Back-to-back adds, strobe held high across the rows
    ALU_VALID = 1'b1;
    foreach (rows[i]) begin
      {a_op, b_op, e} = rows[i];
      nx();
      chk("alu", FLAGS_RDATA, e);
    end
    clr();
    ANY_IRQ_PENDING = 1'b1;
    IE_SET = 1'b1;
    nx();
    clr();
    chk("sei", FLAGS_RDATA, 8'h9b);
    chk("allow", IRQ_ALLOWED, 1'b1);
    ANY_IRQ_PENDING = 1'b0;
    #1 chk("nopend", IRQ_ALLOWED, 1'b0);
    ANY_IRQ_PENDING = 1'b1;
    IE_CLR = 1'b1;
    #1 chk("cli", IRQ_ALLOWED, 1'b0);
    nx();
    clr();
    chk("cli", FLAGS_RDATA, 8'h1b);
    IRQ_RETURN = 1'b1;
    nx();
    clr();
    chk("return_from_irq_op", FLAGS_RDATA, 8'h9b);
    IRQ_TAKE = 1'b1;
    nx();
    clr();
    chk("take", FLAGS_RDATA, 8'h1b);
    FLAGS_WDATA = 8'h5a;
    FLAGS_WE = 1'b1;
    nx();
    clr();
    chk("fwr", FLAGS_RDATA, 8'h5a);
    // Byte write then pair write on consecutive edges
    RF_WR = {1'b1, 1'b0, 5'h05, 16'h00a5};
    nx();
    RF_WR = {1'b0, 1'b1, 5'h1a, 16'h1234};
    nx();
    clr();
    RD_A_ADDR = 5'h05;
    RD_B_ADDR = 5'h1b;
    #1 chk("rda", RD_A_DATA, 8'ha5);
    chk("rdb", RD_B_DATA, 8'h12);
    DS_ADDR = 16'h001b;
    #1 chk("ds", {DS_HIT, DS_RDATA}, 9'h112);
    DS_ADDR = 16'h0020;
    #1 chk("dsmiss", DS_HIT, 1'b0);
    nx();
    DS_ADDR = 16'h0003;
    DS_WDATA = 8'h3c;
    DS_WE = 1'b1;
    nx();
    clr();
    RD_A_ADDR = 5'h03;
    #1 chk("dswr", RD_A_DATA, 8'h3c);
    // Post-increment, then pre-decrement sees the bumped value, then displacement
    PTR_MODE = csr_pkg::CSR_PM_POST;
    PTR_EN = 1'b1;
    #1 chk("post", PTR_ADDR, 16'h1234);
    nx();
    PTR_MODE = csr_pkg::CSR_PM_PRE;
    #1 chk("pre", PTR_ADDR, 16'h1234);
    nx();
    PTR_MODE = csr_pkg::CSR_PM_DISP;
    PTR_DISP = 6'h03;
    #1 chk("disp", PTR_ADDR, 16'h1237);
    nx();
    clr();
    RD_A_ADDR = 5'h1a;
    #1 chk("ptr", RD_W_DATA, 16'h1234);
    // Store a clear bit, a set bit, then load the flag into register 6 bit 3
    BIT_REG = 5'h05;
    BIT_SEL = 3'h1;
    BIT_STORE = 1'b1;
    nx();
    chk("bst0", FLAGS_RDATA, 8'h1a);
    BIT_SEL = 3'h0;
    nx();
    chk("bst1", FLAGS_RDATA, 8'h5a);
    clr();
    BIT_REG = 5'h06;
    BIT_SEL = 3'h3;
    BIT_LOAD = 1'b1;
    nx();
    clr();
    RD_A_ADDR = 5'h06;
    #1 chk("bld", RD_A_DATA, 8'h08);
    SP_WDATA = 8'h04;
    SPH_WE = 1'b1;
    nx();
    SPH_WE = 1'b0;
    SP_WDATA = 8'h00;
    SPL_WE = 1'b1;
    nx();
    clr();
    chk("spwr", {SPH_RDATA, SPL_RDATA}, 16'h0400);
    foreach (sp_ops[i]) begin
      SP_OP = sp_ops[i];
      nx();
      chk("spop", {SPH_RDATA, SPL_RDATA}, sp_exp[i]);
    end
    // Byte write colliding with a push is dropped
    SP_OP = csr_pkg::CSR_SP_PUSH;
    SP_WDATA = 8'h55;
    SPL_WE = 1'b1;
    nx();
    clr();
    chk("spref", {SPH_RDATA, SPL_RDATA}, 16'h03ff);
    RST_N = 1'b0;
    #1 chk("rstf", FLAGS_RDATA, 16'h0000);
    chk("rst", {SPH_RDATA, SPL_RDATA}, 16'h0000);
    nx();
    RST_N = 1'b1;
    nx();
    chk("rstrf", RD_A_DATA, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
